/* File: ogc_pkg.sv */
package ogc_pkg;

  // Register offsets
  localparam logic [7:0] OGC_ADDR_DIFF  = 8'hB0;
  localparam logic [7:0] OGC_ADDR_SE    = 8'hB1;
  localparam logic [7:0] OGC_ADDR_HALT  = 8'hB8;
  localparam logic [7:0] OGC_ADDR_STAT  = 8'hB9;
  localparam logic [7:0] OGC_ADDR_CLR   = 8'hBA;
  localparam logic [7:0] OGC_ADDR_PH_HI = 8'hBF;
  localparam logic [7:0] OGC_ADDR_PH_LO = 8'hC0;

  // Reset values
  localparam logic [7:0]  OGC_RST_DIFF  = 8'h00;
  localparam logic [7:0]  OGC_RST_SE    = 8'h00;
  localparam logic [7:0]  OGC_RST_HALT  = 8'h00;
  localparam logic [7:0]  OGC_RST_CLR   = 8'h00;
  localparam logic [1:0]  OGC_RST_FLAGS = 2'h3;
  localparam logic [15:0] OGC_RST_PHASE = 16'h0000;
  localparam logic [7:0]  OGC_RD_NONE   = 8'h00;

  // Widths and field positions
  localparam int OGC_DIFF_W   = 8;
  localparam int OGC_SE_W     = 4;
  localparam int OGC_NDIV     = 4;
  localparam int OGC_NSYN     = 2;
  localparam int OGC_HALT_W   = 2;
  localparam int OGC_PER_W    = 13;
  localparam int OGC_OCT_W    = 3;
  localparam int OGC_STEP_W   = 4;
  localparam int OGC_HALT_STOP = 1;
  localparam int OGC_HALT_LVL  = 0;
  localparam int OGC_BND_DIV   = 0;

  // Halt selector codes
  localparam logic [1:0] OGC_HALT_LOW  = 2'h2;
  localparam logic [1:0] OGC_HALT_HIGH = 2'h3;

  // Octant decode constants
  localparam logic [2:0] OGC_OCT_HALF = 3'h4;
  localparam logic [3:0] OGC_OCT_FULL = 4'h8;

  // Register port request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] data;
  } ogc_req_t;

  // Committed phase offset
  typedef struct packed {
    logic [OGC_OCT_W-1:0]        octant;
    logic signed [OGC_PER_W-1:0] period;
  } ogc_phase_t;

  // Phase commit sequencer
  typedef enum logic {
    OGC_PH_IDLE  = 1'b0,
    OGC_PH_ARMED = 1'b1
  } ogc_ph_state_t;

endpackage

/* File: ogc_halt_gate.sv */
module ogc_halt_gate
  import ogc_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  ce,
  input  wire logic                  div_in,
  input  wire logic [OGC_HALT_W-1:0] sel,
  output logic                       clk_out
);

  logic halted_reg;
  logic halted_next;
  logic clk_out_next;
  wire  stop_req = sel[OGC_HALT_STOP];
  wire  hold_lvl = sel[OGC_HALT_LVL];

  // Stop only once the clock sits at the hold level
  // stop at level
  assign halted_next  = stop_req & ((halted_reg & (clk_out == hold_lvl)) | (div_in == hold_lvl));
  assign clk_out_next = halted_next ? hold_lvl : div_in;

  // Gate state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      halted_reg <= 1'b0;
      clk_out    <= 1'b0;
    end else if (ce) begin
      halted_reg <= halted_next;
      clk_out    <= clk_out_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_caught;
    ce && stop_req && (div_in == hold_lvl);
  endsequence

  sequence s_hold;
    ce && halted_reg && stop_req && (clk_out == hold_lvl);
  endsequence

  halt_level_a: assert property (s_caught |=> clk_out == $past(hold_lvl))
    else $error("halted clock not at selected level");
  held_stop_a: assert property (s_hold |=> clk_out == $past(hold_lvl))
    else $error("halted clock left its level");
  run_pass_a: assert property (ce && !stop_req |=> clk_out == $past(div_in))
    else $error("running clock not passed through");

endmodule

/* File: ogc_output_ctrl.sv */
// Behaviour
// - diff mask bit enables pair, else tristate
// - single-ended mask bits 3:0 enable outputs
// - halt codes run, stop low, stop high
// - halt fields per synthesizer and divider
// - loss of lock sets sticky flag
// - flags forced set at reset
// - clear bit held high clears flag
// - signed whole-period offset for divider C
// - octant code adds 45 degree steps
module ogc_output_ctrl
  import ogc_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   ce,
  input  wire ogc_req_t               bus_req,
  output logic [7:0]                  rd_data,
  input  wire logic [OGC_NSYN-1:0]    lock_in,
  input  wire logic [OGC_NDIV-1:0]    div_clk_in,
  output logic [OGC_DIFF_W-1:0]       diff_oe,
  output logic [OGC_SE_W-1:0]         se_oe,
  output logic [OGC_NDIV-1:0]         halt_clk_out,
  output logic [OGC_NSYN-1:0]         unlock_flag,
  output ogc_phase_t                  phase_out,
  output logic signed [OGC_STEP_W-1:0] octant_steps
);

  // Register state
  logic [7:0]          diff_reg;
  logic [7:0]          se_reg;
  logic [7:0]          halt_reg;
  logic [7:0]          clr_reg;
  logic [7:0]          ph_hi_reg;
  logic [7:0]          ph_lo_reg;
  logic [OGC_NSYN-1:0] unlock_reg;
  logic [OGC_NSYN-1:0] unlock_next;
  ogc_phase_t          phase_reg;
  ogc_phase_t          stage;
  logic signed [OGC_STEP_W-1:0] steps_reg;
  logic signed [OGC_STEP_W-1:0] steps_next;
  ogc_ph_state_t       ph_state_reg;
  ogc_ph_state_t       ph_state_next;
  logic [7:0]          rd_data_reg;
  logic [7:0]          rd_mux;

  // Synchronisers for lock and divider clocks
  logic [OGC_NSYN-1:0] lock_meta;
  logic [OGC_NSYN-1:0] lock_sync;
  logic [OGC_NDIV-1:0] div_meta;
  logic [OGC_NDIV-1:0] div_sync;
  logic                bnd_dly;

  // Write and read decode
  wire wr_diff  = ce & bus_req.wr & (bus_req.addr == OGC_ADDR_DIFF);
  wire wr_se    = ce & bus_req.wr & (bus_req.addr == OGC_ADDR_SE);
  wire wr_halt  = ce & bus_req.wr & (bus_req.addr == OGC_ADDR_HALT);
  wire wr_clr   = ce & bus_req.wr & (bus_req.addr == OGC_ADDR_CLR);
  wire wr_ph_hi = ce & bus_req.wr & (bus_req.addr == OGC_ADDR_PH_HI);
  wire wr_ph_lo = ce & bus_req.wr & (bus_req.addr == OGC_ADDR_PH_LO);
  wire rd_stb   = ce & bus_req.rd;

  // Divider boundary: rising edge of synth 0 divider C
  wire boundary = div_sync[OGC_BND_DIV] & ~bnd_dly;

  // Read mux, unmapped reads zero
  assign rd_mux =
    (bus_req.addr == OGC_ADDR_DIFF)  ? diff_reg :
    (bus_req.addr == OGC_ADDR_SE)    ? se_reg :
    (bus_req.addr == OGC_ADDR_HALT)  ? halt_reg :
    (bus_req.addr == OGC_ADDR_STAT)  ? {{(8-OGC_NSYN){1'b0}}, unlock_reg} :
    (bus_req.addr == OGC_ADDR_CLR)   ? clr_reg :
    (bus_req.addr == OGC_ADDR_PH_HI) ? ph_hi_reg :
    (bus_req.addr == OGC_ADDR_PH_LO) ? ph_lo_reg :
    OGC_RD_NONE;

  // set on unlock, set beats clear
  assign unlock_next = ~lock_sync | (unlock_reg & ~clr_reg[OGC_NSYN-1:0]);

  // Staged phase word from the two bytes
  assign stage = ogc_phase_t'({ph_hi_reg, ph_lo_reg});

  // octant code to signed 45 degree steps
  function automatic logic signed [OGC_STEP_W-1:0] oct_steps(input logic [OGC_OCT_W-1:0] c);
    logic [OGC_STEP_W-1:0] w;
    w = {1'b0, c};
    if (c < OGC_OCT_HALF) begin
      oct_steps = -$signed(w);
    end else begin
      oct_steps = $signed(OGC_OCT_FULL - w);
    end
  endfunction

  assign steps_next = oct_steps(stage.octant);

  // commit sequencer waits for a boundary
  always_comb begin
    ph_state_next = ph_state_reg;
    case (ph_state_reg)
      OGC_PH_IDLE: begin
        if (wr_ph_lo) begin
          ph_state_next = OGC_PH_ARMED;
        end
      end
      OGC_PH_ARMED: begin
        if (wr_ph_lo) begin
          ph_state_next = OGC_PH_ARMED;
        end else if (ce && boundary) begin
          ph_state_next = OGC_PH_IDLE;
        end
      end
      default: ph_state_next = OGC_PH_IDLE;
    endcase
  end

  // Commit only on an armed boundary
  wire commit = ce & boundary & (ph_state_reg == OGC_PH_ARMED);

  // Two-stage synchronisers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      lock_meta <= '0;
      lock_sync <= '0;
      div_meta  <= '0;
      div_sync  <= '0;
      bnd_dly   <= 1'b0;
    end else if (ce) begin
      lock_meta <= lock_in;
      lock_sync <= lock_meta;
      div_meta  <= div_clk_in;
      div_sync  <= div_meta;
      bnd_dly   <= div_sync[OGC_BND_DIV];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      diff_reg <= OGC_RST_DIFF;
      se_reg   <= OGC_RST_SE;
    end else begin
      if (wr_diff) diff_reg <= bus_req.data;
      if (wr_se)   se_reg   <= bus_req.data;
    end
  end

  // Halt selectors and clear controls
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      halt_reg <= OGC_RST_HALT;
      clr_reg  <= OGC_RST_CLR;
    end else begin
      if (wr_halt) halt_reg <= bus_req.data;
      if (wr_clr)  clr_reg  <= bus_req.data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      unlock_reg <= OGC_RST_FLAGS;
    end else if (ce) begin
      unlock_reg <= unlock_next;
    end
  end

  // Phase staging bytes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ph_hi_reg <= OGC_RST_PHASE[15:8];
      ph_lo_reg <= OGC_RST_PHASE[7:0];
    end else begin
      if (wr_ph_hi) ph_hi_reg <= bus_req.data;
      if (wr_ph_lo) ph_lo_reg <= bus_req.data;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      phase_reg    <= ogc_phase_t'(OGC_RST_PHASE);
      steps_reg    <= '0;
      ph_state_reg <= OGC_PH_IDLE;
    end else if (ce) begin
      ph_state_reg <= ph_state_next;
      if (commit) begin
        phase_reg <= stage;
        steps_reg <= steps_next;
      end
    end
  end

  // Registered read data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data_reg <= OGC_RD_NONE;
    end else if (rd_stb) begin
      rd_data_reg <= rd_mux;
    end
  end

  // one halt gate per divider, two bits each
  genvar gi;
  generate
    for (gi = 0; gi < OGC_NDIV; gi++) begin : g_halt
      ogc_halt_gate u_gate (
        .clk     (clk),
        .rst     (rst),
        .ce      (ce),
        .div_in  (div_sync[gi]),
        .sel     (halt_reg[gi*OGC_HALT_W +: OGC_HALT_W]),
        .clk_out (halt_clk_out[gi])
      );
    end
  endgenerate

  // Outputs straight from flops; upper single-ended bits unused
  assign diff_oe      = diff_reg;
  assign se_oe        = se_reg[OGC_SE_W-1:0];
  assign unlock_flag  = unlock_reg;
  assign phase_out    = phase_reg;
  assign octant_steps = steps_reg;
  assign rd_data      = rd_data_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_clear_held(int i);
    ce && clr_reg[i] && lock_sync[i];
  endsequence

  sequence s_armed_bnd;
    (ph_state_reg == OGC_PH_ARMED) && ce && boundary && !wr_ph_lo;
  endsequence

  diff_mask_a: assert property (wr_diff |=> diff_oe == $past(bus_req.data))
    else $error("differential enable not updated");
  se_mask_a: assert property (wr_se |=> se_oe == $past(bus_req.data[OGC_SE_W-1:0]))
    else $error("single-ended enable not updated");
  halt_field_a: assert property (ce && halt_reg[3:2] == OGC_HALT_HIGH && div_sync[1]
    |=> halt_clk_out[1])
    else $error("divider D halt field misrouted");
  flag_set_a: assert property (ce && !lock_sync[0] |=> unlock_flag[0])
    else $error("unlock flag not set");
  flag_keep_a: assert property (unlock_flag[1] && !clr_reg[1] |=> unlock_flag[1])
    else $error("unlock flag dropped without clear");
  flag_reset_a: assert property (disable iff (1'b0) rst |-> unlock_flag == OGC_RST_FLAGS)
    else $error("unlock flags not set in reset");
  flag_clear_a: assert property (s_clear_held(0) |=> !unlock_flag[0])
    else $error("unlock flag not cleared");
  // period offset only moves on commit
  period_hold_a: assert property (!$stable(phase_out) |-> $past(commit))
    else $error("phase offset moved without commit");
  oct_decode_a: assert property (commit && stage.octant == OGC_OCT_HALF
    |=> octant_steps == $signed(OGC_STEP_W'(4)))
    else $error("octant 180 degree decode wrong");
  bnd_commit_a: assert property (s_armed_bnd
    |=> phase_out == $past(stage) && ph_state_reg == OGC_PH_IDLE)
    else $error("offset not applied at boundary");

  rd_diff_a: assert property (rd_stb && bus_req.addr == OGC_ADDR_DIFF
    |=> rd_data == $past(diff_oe))
    else $error("differential mask read back wrong");
  ce_freeze_a: assert property (!ce |=> $stable(diff_oe) && $stable(se_oe)
    && $stable(unlock_flag) && $stable(phase_out) && $stable(halt_clk_out))
    else $error("state moved while clock enable low");
  halt_low_a: assert property (ce && halt_reg[OGC_HALT_W-1:0] == OGC_HALT_LOW
    && !div_sync[0] |=> !halt_clk_out[0])
    else $error("divider C halt field misrouted");
  flag_set1_a: assert property (ce && !lock_sync[1] |=> unlock_flag[1])
    else $error("second unlock flag not set");
  flag_keep0_a: assert property (unlock_flag[0] && !clr_reg[0] |=> unlock_flag[0])
    else $error("first unlock flag dropped without clear");
  rd_stat_a: assert property (rd_stb && bus_req.addr == OGC_ADDR_STAT
    |=> rd_data[OGC_NSYN-1:0] == $past(unlock_flag))
    else $error("status read back wrong");
  flag_clear1_a: assert property (s_clear_held(1) |=> !unlock_flag[1])
    else $error("second unlock flag not cleared");
  steps_hold_a: assert property (!$stable(octant_steps) |-> $past(commit))
    else $error("octant steps moved without commit");
  idle_hold_a: assert property (ph_state_reg == OGC_PH_IDLE |=> $stable(phase_out))
    else $error("offset moved while not armed");

endmodule

/* File: ogc_host_model.sv */
// Host side: register strobes and free divider clocks
module ogc_host_model
  import ogc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       div_run,
  input  wire logic [7:0] rd_data,
  output ogc_req_t        bus_req,
  output logic [3:0]      div_clk_in
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] div_cnt;
  logic       run_q;

  initial begin
    bus_req = '0;
    div_clk_in = 4'h5;
    div_cnt = 2'h0;
  end

  // Dividers toggle every third cycle while running
  always @(posedge clk) begin
    run_q = div_run;
    #1;
    if (run_q) begin
      div_cnt = (div_cnt == 2'h2) ? 2'h0 : div_cnt + 2'h1;
      if (div_cnt == 2'h0)
        div_clk_in = ~div_clk_in;
    end
  end

  // One write, held for exactly one taken edge
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    bus_req.addr = a;
    bus_req.data = (a == OGC_ADDR_SE) ? {4'h0, d[3:0]} : d;
    bus_req.wr = 1'b1;
    @(posedge clk);
    #1;
    bus_req.wr = 1'b0;
  endtask

  // One read, data taken after the read edge
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    bus_req.addr = a;
    bus_req.rd = 1'b1;
    @(posedge clk);
    #1;
    bus_req.rd = 1'b0;
    d = rd_data;
  endtask
endmodule

/* File: tb_output_clock_gating_and_phase_ctrl.sv */
module tb_output_clock_gating_and_phase_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  import ogc_pkg::*;
  logic                         clk;
  logic                         rst;
  logic                         ce;
  logic                         div_run;
  ogc_req_t                     bus_req;
  logic [7:0]                   rd_data;
  logic [1:0]                   lock_in;
  logic [3:0]                   div_clk_in;
  logic [7:0]                   diff_oe;
  logic [3:0]                   se_oe;
  logic [3:0]                   halt_clk_out;
  logic [1:0]                   unlock_flag;
  ogc_phase_t                   phase_out;
  logic signed [3:0]            octant_steps;
  int                           fails = 0;
  int                           n_checks = 0;
  int                           cycles = 0;

  ogc_output_ctrl u_dut (.clk(clk), .rst(rst), .ce(ce), .bus_req(bus_req), .rd_data(rd_data),
    .lock_in(lock_in), .div_clk_in(div_clk_in), .diff_oe(diff_oe), .se_oe(se_oe),
    .halt_clk_out(halt_clk_out), .unlock_flag(unlock_flag), .phase_out(phase_out),
    .octant_steps(octant_steps));
  ogc_host_model u_host (.clk(clk), .div_run(div_run), .rd_data(rd_data), .bus_req(bus_req),
    .div_clk_in(div_clk_in));

  // Clock and hang guard
  initial clk = 1'b0;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      fails++;
      give_verdict();
    end
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic t_reset();
    logic [7:0] d;
    logic [7:0] addrs [7] = '{OGC_ADDR_DIFF, OGC_ADDR_SE, OGC_ADDR_HALT, OGC_ADDR_CLR,
                              OGC_ADDR_PH_HI, OGC_ADDR_PH_LO, 8'h00};
    chk("unlock_flag", 16'h0003, {14'h0, unlock_flag});
    chk("diff_oe", 16'h0000, {8'h00, diff_oe});
    chk("se_oe", 16'h0000, {12'h000, se_oe});
    chk("phase_out", 16'h0000, phase_out);
    u_host.rd_reg(OGC_ADDR_STAT, d);
    chk("status read", 16'h0003, {8'h00, d});
    foreach (addrs[i]) begin
      u_host.rd_reg(addrs[i], d);
      chk("reset read", 16'h0000, {8'h00, d});
    end
  endtask

  task automatic t_drive();
    logic [7:0] d;
    u_host.wr_reg(OGC_ADDR_DIFF, 8'hA5);
    chk("diff_oe", 16'h00A5, {8'h00, diff_oe});
    u_host.wr_reg(OGC_ADDR_DIFF, 8'h5A);
    chk("diff_oe", 16'h005A, {8'h00, diff_oe});
    u_host.wr_reg(OGC_ADDR_SE, 8'h0A);
    chk("se_oe", 16'h000A, {12'h000, se_oe});
    u_host.wr_reg(OGC_ADDR_SE, 8'h05);
    chk("se_oe", 16'h0005, {12'h000, se_oe});
    u_host.rd_reg(OGC_ADDR_DIFF, d);
    chk("diff read", 16'h005A, {8'h00, d});
    ce = 1'b0;
    u_host.wr_reg(OGC_ADDR_DIFF, 8'hFF);
    ce = 1'b1;
    chk("diff_oe frozen", 16'h005A, {8'h00, diff_oe});
  endtask

  task automatic t_flags();
    logic [7:0] d;
    lock_in = 2'b11;
    repeat (5) @(posedge clk);
    #1;
    chk("flag sticky", 16'h0003, {14'h0, unlock_flag});
    u_host.wr_reg(OGC_ADDR_CLR, 8'h03);
    repeat (2) @(posedge clk);
    #1;
    chk("flag cleared", 16'h0000, {14'h0, unlock_flag});
    u_host.wr_reg(OGC_ADDR_CLR, 8'h00);
    lock_in[0] = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    chk("flag set", 16'h0001, {14'h0, unlock_flag});
    lock_in[0] = 1'b1;
    repeat (5) @(posedge clk);
    u_host.rd_reg(OGC_ADDR_STAT, d);
    chk("status read", 16'h0001, {8'h00, d});
    u_host.wr_reg(OGC_ADDR_CLR, 8'h03);
    lock_in[1] = 1'b0;
    repeat (5) @(posedge clk);
    #1;
    chk("set beats clear", 16'h0002, {14'h0, unlock_flag});
    lock_in[1] = 1'b1;
    repeat (5) @(posedge clk);
    #1;
    chk("held clear", 16'h0000, {14'h0, unlock_flag});
    u_host.wr_reg(OGC_ADDR_CLR, 8'h00);
  endtask

  task automatic t_halt(input logic [7:0] sel);
    logic [3:0] seen0;
    logic [3:0] seen1;
    seen0 = 4'h0;
    seen1 = 4'h0;
    div_run = 1'b1;
    u_host.wr_reg(OGC_ADDR_HALT, sel);
    repeat (12) @(posedge clk);
    for (int i = 0; i < 24; i++) begin
      @(posedge clk);
      #1;
      seen0 |= ~halt_clk_out;
      seen1 |= halt_clk_out;
    end
    for (int i = 0; i < 4; i++)
      chk("halt gate", {14'h0, sel[2*i+1] ? {sel[2*i], ~sel[2*i]} : 2'b11},
          {14'h0, seen1[i], seen0[i]});
  endtask

  task automatic t_phase();
    logic [2:0]  c;
    logic [12:0] p;
    logic [15:0] old;
    logic [3:0]  steps [8] = '{4'h0, 4'hF, 4'hE, 4'hD, 4'h4, 4'h3, 4'h2, 4'h1};
    for (int i = 0; i < 8; i++) begin
      c = 3'(i + 1);
      p = {c, 10'h3FF} ^ 13'h1000;
      div_run = 1'b0;
      repeat (4) @(posedge clk);
      old = phase_out;
      u_host.wr_reg(OGC_ADDR_PH_HI, {c, p[12:8]});
      u_host.wr_reg(OGC_ADDR_PH_LO, p[7:0]);
      repeat (10) @(posedge clk);
      #1;
      chk("phase held", old, phase_out);
      div_run = 1'b1;
      for (int k = 0; k < 30 && phase_out !== {c, p}; k++) begin
        @(posedge clk);
        #1;
      end
      chk("phase_out", {c, p}, phase_out);
      chk("octant_steps", {12'h000, steps[c]}, {12'h000, octant_steps});
    end
  endtask

  // Main sequence
  initial begin
    rst = 1'b0;
    ce = 1'b1;
    lock_in = 2'b00;
    div_run = 1'b0;
    // Raise reset after time zero so its edge is never missed
    #1;
    rst = 1'b1;
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset();
    t_drive();
    t_flags();
    t_halt(8'hE4);
    t_halt(8'h1B);
    t_halt(8'h4E);
    t_halt(8'h00);
    t_phase();
    give_verdict();
  end
endmodule
